// ==== verilog/smsp_core.sv ====
// Operation
// - transfer interrupt request only when control bit 7 set; resets 0
// - port runs only while control bit 6 set; resets 0
// - control bit 4 selects master when 1, slave when 0; resets 1
// - idle serial clock rests at polarity bit 3 level
// - polarity and phase choose the data change edge; idle follows polarity
// - slave, equal polarity and phase: change on falling, sample on rising
// - slave, differing settings: change on rising, sample on falling
// - master rate code is extension bits 1:0 above control bits 1:0
// - four-bit code divides system clock; 0010 gives divide by 8
// - status bit 7 set on each completed transfer, sticky until cleared
// - status bit 6 set on data write while transmit queue full
// - status bits 3 and 2 show transmit queue full and empty
// - status bits 1 and 0 show receive queue full and empty
// - data register: write queues a byte, read returns received byte
// - master: data write starts a transfer; read returns slave byte
// - slave with empty transmit queue makes no exchange
// - queues hold 16 entries, 256 when path mux is 3
`timescale 1ns/1ps
module smsp_core
	import smsp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [15:0] regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	output logic [7:0]       regRdData,
	output logic             irq,
	input  wire logic        sckIn,
	output logic             sckOut,
	output logic             sckOeN,
	input  wire logic        csInN,
	output logic             csOutN,
	output logic             csOeN,
	input  wire logic        mosiIn,
	output logic             mosiOut,
	output logic             mosiOeN,
	input  wire logic        misoIn,
	output logic             misoOut,
	output logic             misoOeN
);

	// ----------------------------------------
	// state and queue memories
	// ----------------------------------------
	smsp_regs_t   st_reg, st_next;
	smsp_ram_wr_t txWr, rxWr;
	logic [7:0]   txHead, rxHead, depthMask, rxNew;
	logic [8:0]   depth;
	logic         txFull, txEmpty, rxFull, rxEmpty;
	logic         txPop, rxPush, clock_polarity, clock_phase, en, master;
	logic         sRise, sFall, sSample, sChange, lead, doSample;

	smsp_ram u_txRam (
		.clk    (clk),
		.wr     (txWr),
		.rdAddr (st_next.txRp),
		.rdData (txHead)
	);

	smsp_ram u_rxRam (
		.clk    (clk),
		.wr     (rxWr),
		.rdAddr (st_next.rxRp),
		.rdData (rxHead)
	);

	// queue geometry and flags
	always_comb begin
		depth = (st_reg.pathMux == PATH_MUX_WIDE) ? DEPTH_LARGE : DEPTH_SMALL;
		depthMask = 8'(depth - 9'h001);
		txFull = (st_reg.txCnt == depth);
		txEmpty = (st_reg.txCnt == 9'h000);
		rxFull = (st_reg.rxCnt == depth);
		rxEmpty = (st_reg.rxCnt == 9'h000);
		clock_polarity = st_reg.control[CTL_CLOCK_POLARITY];
		clock_phase = st_reg.control[CTL_CLOCK_PHASE];
		en = st_reg.control[CTL_PORT_EN];
		master = st_reg.control[CTL_MASTER];
		sRise = sckIn && !st_reg.sckPrev;
		sFall = !sckIn && st_reg.sckPrev;
		sSample = (clock_polarity == clock_phase) ? sRise : sFall;
		sChange = (clock_polarity == clock_phase) ? sFall : sRise;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		txPop = 1'b0;
		rxPush = 1'b0;
		rxNew = st_reg.rxShift;
		lead = !st_reg.edgeCnt[0];
		doSample = 1'b0;
		st_next.sckPrev = sckIn;
		// register writes
		if (regWrEn) begin
			case (regAddr)
				ADDR_CONTROL: st_next.control = regWrData & CTL_WR_MASK;
				ADDR_STATUS: begin
					if (regWrData[STS_DONE]) begin
						st_next.doneFlag = 1'b0;
					end
					if (regWrData[STS_WRITE_COLLISION_FLAG]) begin
						st_next.wcolFlag = 1'b0;
					end
				end
				ADDR_DATA: begin
					if (txFull) begin
						st_next.wcolFlag = 1'b1;
					end
				end
				ADDR_RATE_EXT: st_next.rateExt = regWrData & EXT_WR_MASK;
				ADDR_MASK: st_next.mask = regWrData;
				ADDR_PATH_MUX: st_next.pathMux = regWrData[2:0];
				default: ;
			endcase
		end
		// serial engine
		case (st_reg.state)
			ST_IDLE: begin
				st_next.sckOut = clock_polarity;
				st_next.csOutN = 1'b1;
				st_next.sckOeN = !(en && master);
				st_next.csOeN = !(en && master);
				st_next.mosiOeN = !(en && master);
				st_next.misoOeN = 1'b1;
				st_next.edgeCnt = 4'h0;
				st_next.divCnt = smsp_half_div({st_reg.rateExt[1:0], st_reg.control[1:0]}) - 11'h001;
				if (en && master && !txEmpty) begin
					txPop = 1'b1;
					st_next.csOutN = 1'b0;
					st_next.txShift = clock_phase ? txHead : {txHead[6:0], 1'b0};
					st_next.mosiOut = clock_phase ? st_reg.mosiOut : txHead[7];
					st_next.state = ST_MXFER;
				end else if (en && !master && !csInN) begin
					if (txEmpty) begin
						st_next.state = ST_SSKIP;
					end else begin
						txPop = 1'b1;
						st_next.misoOeN = 1'b0;
						st_next.txShift = clock_phase ? txHead : {txHead[6:0], 1'b0};
						st_next.misoOut = clock_phase ? st_reg.misoOut : txHead[7];
						st_next.state = ST_SXFER;
					end
				end
			end
			ST_MXFER: begin
				if (!en || !master) begin
					st_next.state = ST_IDLE;
				end else if (st_reg.divCnt != 11'h000) begin
					st_next.divCnt = st_reg.divCnt - 11'h001;
				end else begin
					st_next.divCnt = smsp_half_div({st_reg.rateExt[1:0], st_reg.control[1:0]}) - 11'h001;
					st_next.sckOut = !st_reg.sckOut;
					st_next.edgeCnt = st_reg.edgeCnt + 4'h1;
					doSample = lead ^ clock_phase;
					if (doSample) begin
						rxNew = {st_reg.rxShift[6:0], misoIn};
						st_next.rxShift = rxNew;
					end else if (st_reg.edgeCnt != LAST_EDGE) begin
						st_next.mosiOut = st_reg.txShift[7];
						st_next.txShift = {st_reg.txShift[6:0], 1'b0};
					end
					if (st_reg.edgeCnt == LAST_EDGE) begin
						rxPush = 1'b1;
						st_next.doneFlag = 1'b1;
						st_next.csOutN = 1'b1;
						st_next.state = ST_IDLE;
					end
				end
			end
			ST_SXFER: begin
				if (csInN || !en || master) begin
					st_next.misoOeN = 1'b1;
					st_next.state = ST_IDLE;
				end else if (sSample) begin
					rxNew = {st_reg.rxShift[6:0], mosiIn};
					st_next.rxShift = rxNew;
					st_next.edgeCnt = st_reg.edgeCnt + 4'h1;
					if (st_reg.edgeCnt == LAST_SAMPLE) begin
						rxPush = 1'b1;
						st_next.doneFlag = 1'b1;
						st_next.state = ST_IDLE;
					end
				end else if (sChange) begin
					st_next.misoOut = st_reg.txShift[7];
					st_next.txShift = {st_reg.txShift[6:0], 1'b0};
				end
			end
			ST_SSKIP: begin
				st_next.misoOeN = 1'b1;
				if (csInN || !en || master) begin
					st_next.state = ST_IDLE;
				end
			end
			default: st_next.state = ST_IDLE;
		endcase
		// transmit queue
		if (regWrEn && (regAddr == ADDR_DATA) && !txFull) begin
			st_next.txWp = (st_reg.txWp + 8'h01) & depthMask;
		end
		if (txPop) begin
			st_next.txRp = (st_reg.txRp + 8'h01) & depthMask;
		end
		st_next.txCnt = st_reg.txCnt + 9'(regWrEn && (regAddr == ADDR_DATA) && !txFull)
			- 9'(txPop);
		// receive queue, a byte arriving into a full queue is dropped
		if (rxPush && !rxFull) begin
			st_next.rxWp = (st_reg.rxWp + 8'h01) & depthMask;
		end
		if (regRdEn && (regAddr == ADDR_DATA) && !rxEmpty) begin
			st_next.rxRp = (st_reg.rxRp + 8'h01) & depthMask;
		end
		st_next.rxCnt = st_reg.rxCnt + 9'(rxPush && !rxFull)
			- 9'(regRdEn && (regAddr == ADDR_DATA) && !rxEmpty);
		// read data, one cycle after the strobe
		st_next.rdData = 8'h00;
		if (regRdEn) begin
			case (regAddr)
				ADDR_CONTROL: st_next.rdData = st_reg.control;
				ADDR_STATUS: st_next.rdData = {st_reg.doneFlag, st_reg.wcolFlag, 2'b00,
					txFull, txEmpty, rxFull, rxEmpty};
				ADDR_DATA: st_next.rdData = rxEmpty ? 8'h00 : rxHead;
				ADDR_RATE_EXT: st_next.rdData = st_reg.rateExt;
				ADDR_MASK: st_next.rdData = st_reg.mask;
				ADDR_PATH_MUX: st_next.rdData = {5'h00, st_reg.pathMux};
				default: st_next.rdData = 8'h00;
			endcase
		end
		// interrupt from unmasked sticky flags
		st_next.irq = (st_next.doneFlag && st_next.control[CTL_IRQ_EN]
			&& st_next.mask[STS_DONE])
			|| (st_next.wcolFlag && st_next.mask[STS_WRITE_COLLISION_FLAG]);
		// synchronous reset
		if (srst) begin
			st_next = '0;
			st_next.control = RST_CONTROL;
			st_next.rateExt = RST_RATE_EXT;
			st_next.mask = RST_MASK;
			st_next.state = ST_IDLE;
			st_next.sckOeN = 1'b1;
			st_next.csOeN = 1'b1;
			st_next.csOutN = 1'b1;
			st_next.mosiOeN = 1'b1;
			st_next.misoOeN = 1'b1;
		end
	end

	// queue write ports
	always_comb begin
		txWr = '{we: regWrEn && (regAddr == ADDR_DATA) && !txFull,
			addr: st_reg.txWp, data: regWrData};
		rxWr = '{we: rxPush && !rxFull, addr: st_reg.rxWp, data: rxNew};
	end

	// ----------------------------------------
	// state register and outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	assign regRdData = st_reg.rdData;
	assign irq = st_reg.irq;
	assign sckOut = st_reg.sckOut;
	assign sckOeN = st_reg.sckOeN;
	assign csOutN = st_reg.csOutN;
	assign csOeN = st_reg.csOeN;
	assign mosiOut = st_reg.mosiOut;
	assign mosiOeN = st_reg.mosiOeN;
	assign misoOut = st_reg.misoOut;
	assign misoOeN = st_reg.misoOeN;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence seqDataWrite;
		regWrEn && (regAddr == ADDR_DATA) && !txFull && en && master
			&& (st_reg.state == ST_IDLE) && txEmpty;
	endsequence

	sequence seqLaunch;
		##1 (st_reg.txCnt == 9'h001) ##1 (st_reg.state == ST_MXFER) && !csOutN;
	endsequence

	AST_IRQ_FOLLOWS: assert property (
		(st_reg.doneFlag && !st_reg.control[CTL_IRQ_EN] && !st_reg.wcolFlag) |-> !irq)
		else $error("interrupt raised while disabled");

	AST_IRQ_RAISE: assert property (
		(st_reg.doneFlag && st_reg.control[CTL_IRQ_EN] && st_reg.mask[STS_DONE]) |-> irq)
		else $error("interrupt missing with flag and enable set");

	AST_PORT_OFF: assert property (
		(!en && (st_reg.state == ST_IDLE)) |=> (st_reg.state == ST_IDLE))
		else $error("engine left idle while port disabled");

	AST_MASTER_DEFAULT: assert property (
		$past(srst) |-> st_reg.control[CTL_MASTER])
		else $error("master select not set after reset");

	AST_IDLE_LEVEL: assert property (
		((st_reg.state == ST_IDLE) && $past(st_reg.state == ST_IDLE) && !sckOeN)
		|-> (sckOut == $past(clock_polarity)))
		else $error("idle clock not at polarity level");

	AST_EDGE_PACE: assert property (
		((st_reg.state == ST_MXFER) && $past(st_reg.state == ST_MXFER)
		&& $changed(sckOut)) |-> ($past(st_reg.divCnt) == 11'h000))
		else $error("serial clock toggled before divider expired");

	AST_SLAVE_SAMPLE: assert property (
		((st_reg.state == ST_SXFER) && !csInN && en && !master && sSample)
		|=> (st_reg.rxShift[0] == $past(mosiIn)))
		else $error("slave did not sample on its sample edge");

	AST_DONE_STICKY: assert property (
		(st_reg.doneFlag && !(regWrEn && (regAddr == ADDR_STATUS)
		&& regWrData[STS_DONE])) |=> st_reg.doneFlag)
		else $error("transfer flag dropped without a clear");

	AST_WRITE_COLLISION_FLAG: assert property (
		(regWrEn && (regAddr == ADDR_DATA) && txFull) |=> st_reg.wcolFlag)
		else $error("write collision not flagged");

	AST_STATUS_READ: assert property (
		(regRdEn && (regAddr == ADDR_STATUS))
		|=> (regRdData[3:0] == $past({txFull, txEmpty, rxFull, rxEmpty})))
		else $error("status queue bits wrong");

	AST_RX_READ: assert property (
		(regRdEn && (regAddr == ADDR_DATA) && !rxEmpty) |=> (regRdData == $past(rxHead)))
		else $error("data read did not return queue head");

	AST_MASTER_START: assert property (seqDataWrite |-> seqLaunch)
		else $error("data write did not start a master transfer");

	AST_SLAVE_SKIP: assert property (
		((st_reg.state == ST_IDLE) && en && !master && !csInN && txEmpty)
		|=> ((st_reg.state == ST_SSKIP) && misoOeN))
		else $error("slave exchanged with an empty queue");

	AST_DEPTH: assert property (
		(st_reg.txCnt <= depth) && (st_reg.rxCnt <= depth))
		else $error("queue count beyond depth");

	AST_PIN_DIR: assert property (
		(st_reg.state == ST_MXFER) |-> (!sckOeN && !csOeN && !csOutN))
		else $error("master not driving clock and select");

endmodule

// ==== verilog/smsp_pkg.sv ====
package smsp_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [15:0] ADDR_CONTROL  = 16'h2540;
	localparam logic [15:0] ADDR_STATUS   = 16'h2541;
	localparam logic [15:0] ADDR_DATA     = 16'h2542;
	localparam logic [15:0] ADDR_RATE_EXT = 16'h2543;
	localparam logic [15:0] ADDR_MASK     = 16'h2544;
	localparam logic [15:0] ADDR_PATH_MUX = 16'h277F;

	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int CTL_IRQ_EN = 7;
	localparam int CTL_PORT_EN = 6;
	localparam int CTL_MASTER = 4;
	localparam int CTL_CLOCK_POLARITY = 3;
	localparam int CTL_CLOCK_PHASE = 2;
	localparam int STS_DONE = 7;
	localparam int STS_WRITE_COLLISION_FLAG = 6;
	localparam logic [7:0] CTL_WR_MASK  = 8'hDF;
	localparam logic [7:0] RST_CONTROL  = 8'h10;
	localparam logic [7:0] EXT_WR_MASK  = 8'hC3;
	localparam logic [7:0] RST_RATE_EXT = 8'h02;
	localparam logic [7:0] RST_MASK     = 8'hC0;
	localparam logic [2:0] PATH_MUX_WIDE = 3'h3;
	localparam logic [8:0] DEPTH_SMALL  = 9'h010;
	localparam logic [8:0] DEPTH_LARGE  = 9'h100;
	localparam logic [3:0] LAST_EDGE    = 4'hF;
	localparam logic [3:0] LAST_SAMPLE  = 4'h7;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_MXFER = 2'b01,
		ST_SXFER = 2'b10,
		ST_SSKIP = 2'b11
	} smsp_state_t;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} smsp_ram_wr_t;

	typedef struct packed {
		smsp_state_t state;
		logic [7:0]  control, rateExt, mask, rdData, txShift, rxShift;
		logic [2:0]  pathMux;
		logic        doneFlag, wcolFlag, irq;
		logic [7:0]  txWp, txRp, rxWp, rxRp;
		logic [8:0]  txCnt, rxCnt;
		logic [10:0] divCnt;
		logic [3:0]  edgeCnt;
		logic        sckOut, sckOeN, csOutN, csOeN;
		logic        mosiOut, mosiOeN, misoOut, misoOeN, sckPrev;
	} smsp_regs_t;

	// half period of the serial clock in system clocks, by divider code
	function automatic logic [10:0] smsp_half_div(input logic [3:0] code);
		case (code)
			4'h3: smsp_half_div = 11'h010;
			4'h4: smsp_half_div = 11'h020;
			4'h5: smsp_half_div = 11'h008;
			4'h6: smsp_half_div = 11'h040;
			4'h7: smsp_half_div = 11'h080;
			4'h8: smsp_half_div = 11'h100;
			4'h9: smsp_half_div = 11'h200;
			4'hA: smsp_half_div = 11'h400;
			4'hB, 4'hC, 4'hD, 4'hE, 4'hF: smsp_half_div = 11'h7FF;
			default: smsp_half_div = 11'h004;
		endcase
	endfunction

endpackage

// ==== verilog/smsp_ram.sv ====
`timescale 1ns/1ps
module smsp_ram
	import smsp_pkg::*;
(
	input  wire logic         clk,
	input  wire smsp_ram_wr_t wr,
	input  wire logic [7:0]   rdAddr,
	output logic [7:0]        rdData
);

	// ----------------------------------------
	// storage, registered read with write bypass
	// ----------------------------------------
	logic [7:0] mem [256];

	// write port
	always_ff @(posedge clk) begin
		if (wr.we) begin
			mem[wr.addr] <= wr.data;
		end
	end

	// read port shows a byte written to the same word in the same cycle
	always_ff @(posedge clk) begin
		if (wr.we && (wr.addr == rdAddr)) begin
			rdData <= wr.data;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule

// ==== verif/smsp_partner.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// far side serial slave model
// ----------------------------------------
module smsp_partner
	import smsp_pkg::*;
(
	input  wire logic       clock_phase,
	input  wire logic       sck,
	input  wire logic       csN,
	input  wire logic       mosi,
	input  wire logic [7:0] txByte,
	output logic            miso,
	output logic [7:0]      rxByte
);
	int nEdge = 16;
	int idx;

	initial begin
		miso = 1'b0;
		rxByte = 8'h00;
	end

	// select falls: load reply, phase 0 shows the first bit at once
	always @(negedge csN) begin
		nEdge = 0;
		idx = 0;
		if (!clock_phase) begin
			miso = txByte[7];
			idx = 1;
		end
	end

	// a released line shows the inverse of its last bit
	always @(posedge csN) miso = ~miso;

	// phase 0 samples on odd edges, phase 1 on even edges; the others shift
	// edges are counted, not gated by select, which rises in the step of the last edge
	always @(sck) begin
		if (nEdge < 16) begin
			nEdge = nEdge + 1;
			if (nEdge[0] != clock_phase) begin
				rxByte = {rxByte[6:0], mosi};
			end else if (idx < 8) begin
				miso = txByte[7 - idx];
				idx = idx + 1;
			end
		end
	end
endmodule

// ==== verif/spi_master_slave_port_test.sv ====
`timescale 1ns/1ps
module spi_master_slave_port_test
	import smsp_pkg::*;
;
	logic        clk, srst, regWrEn, regRdEn, irq, clock_phase;
	logic        sckOut, sckOeN, csOutN, csOeN, mosiOut, mosiOeN, misoOut, misoOeN;
	logic        tbSck, tbCsN, tbMosi, slvMiso, sckW, csW, mosiW, misoW;
	logic [15:0] regAddr;
	logic [7:0]  regWrData, regRdData, slvReply, slvRx;
	int          failCount, checksDone;

	// wire levels worked out from the block's output enables
	assign sckW  = sckOeN ? tbSck : sckOut;
	assign csW   = csOeN ? tbCsN : csOutN;
	assign mosiW = mosiOeN ? tbMosi : mosiOut;
	assign misoW = misoOeN ? slvMiso : misoOut;

	smsp_core dut_u (
		.clk, .srst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .irq,
		.sckIn(sckW), .sckOut, .sckOeN, .csInN(csW), .csOutN, .csOeN,
		.mosiIn(mosiW), .mosiOut, .mosiOeN, .misoIn(misoW), .misoOut, .misoOeN
	);

	smsp_partner peer_u (
		.clock_phase, .sck(sckW), .csN(csW), .mosi(mosiW), .txByte(slvReply),
		.miso(slvMiso), .rxByte(slvRx)
	);

	always #5 clk = ~clk;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checksDone++;
		if (seen !== want) begin
			failCount++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		@(posedge clk);
		d = regRdData;
	endtask

	task automatic closeOut();
		if (failCount == 0 && checksDone > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic reset_values();
		logic [7:0] d;
		check({6'h00, sckOeN, irq}, 8'h02);
		rd(ADDR_CONTROL, d);
		check(d, 8'h10);
		rd(ADDR_RATE_EXT, d);
		check(d, 8'h02);
		wr(ADDR_STATUS, 8'h3F);
		rd(ADDR_STATUS, d);
		check(d, 8'h05);
		rd(16'h2545, d);
		check(d, 8'h00);
	endtask

	// one master byte with a given mode, divider code and interrupt enable
	task automatic master_byte(input logic [1:0] md, input logic [3:0] code,
		input logic ie, input logic [7:0] b, input logic [7:0] hp);
		int n;
		int half;
		logic [7:0] d;
		clock_phase = md[0];
		slvReply = ~b;
		wr(ADDR_RATE_EXT, {6'h00, code[3:2]});
		wr(ADDR_CONTROL, {ie, 3'b101, md, code[1:0]});
		@(posedge clk);
		check({7'h00, sckW}, {7'h00, md[1]});
		check({5'h00, sckOeN, csOeN, mosiOeN}, 8'h00);
		wr(ADDR_DATA, b);
		for (n = 0; n < 9000 && sckW === md[1]; n++) @(posedge clk);
		for (half = 0; half < 9000 && sckW !== md[1]; half++) @(posedge clk);
		check(half[7:0], hp);
		for (n = 0; n < 9000 && csOutN !== 1'b1; n++) @(posedge clk);
		repeat (3) @(posedge clk);
		check({7'h00, irq}, {7'h00, ie});
		check(slvRx, b);
		rd(ADDR_STATUS, d);
		check(d, 8'h84);
		rd(ADDR_DATA, d);
		check(d, ~b);
		wr(ADDR_STATUS, 8'h80);
		rd(ADDR_STATUS, d);
		check(d, 8'h05);
		check({7'h00, irq}, 8'h00);
	endtask

	// fill the transmit queue past full, then let it run into the receive queue
	task automatic queue_fill();
		logic [7:0] d;
		wr(ADDR_CONTROL, 8'h10);
		for (int i = 0; i < 17; i++) wr(ADDR_DATA, 8'(i));
		rd(ADDR_STATUS, d);
		check(d, 8'h49);
		check({7'h00, irq}, 8'h01);
		wr(ADDR_STATUS, 8'h40);
		rd(ADDR_STATUS, d);
		check(d, 8'h09);
		wr(ADDR_MASK, 8'h00);
		wr(ADDR_DATA, 8'hFF);
		check({7'h00, irq}, 8'h00);
		wr(ADDR_STATUS, 8'h40);
		wr(ADDR_MASK, 8'hC0);
		clock_phase = 1'b0;
		slvReply = 8'h66;
		wr(ADDR_RATE_EXT, 8'h00);
		wr(ADDR_CONTROL, 8'h52);
		d = 8'h00;
		for (int n = 0; n < 1000 && d[1] !== 1'b1; n++) rd(ADDR_STATUS, d);
		check(d, 8'h86);
		check(slvRx, 8'h0F);
		for (int i = 0; i < 16; i++) begin
			rd(ADDR_DATA, d);
			check(d, 8'h66);
		end
		wr(ADDR_STATUS, 8'h80);
		rd(ADDR_STATUS, d);
		check(d, 8'h05);
	endtask

	// bench acts as master towards the block in slave role
	task automatic slave_byte(input logic [1:0] md, input logic load, input logic [7:0] b);
		logic [7:0] mi;
		logic [7:0] d;
		tbSck <= md[1];
		wr(ADDR_CONTROL, {4'hC, md, 2'b00});
		if (load) wr(ADDR_DATA, ~b);
		tbCsN <= 1'b0;
		tbMosi <= b[7];
		mi = 8'h00;
		for (int i = 0; i < 16; i++) begin
			repeat (6) @(posedge clk);
			if (i == 8) check({4'h0, sckOeN, csOeN, mosiOeN, misoOeN}, {7'h07, ~load});
			if (i[0] == md[0])
				mi = {mi[6:0], misoW};
			else if (i < 15)
				tbMosi <= b[7 - (i + 1) / 2];
			tbSck <= ~tbSck;
		end
		repeat (6) @(posedge clk);
		tbCsN <= 1'b1;
		tbMosi <= ~tbMosi;
		repeat (3) @(posedge clk);
		check({7'h00, irq}, {7'h00, load});
		rd(ADDR_STATUS, d);
		check(d, load ? 8'h84 : 8'h05);
		if (load) begin
			check(mi, ~b);
			rd(ADDR_DATA, d);
			check(d, b);
			wr(ADDR_STATUS, 8'h80);
		end
	endtask

	// wide queue: path mux 3 gives 256 entries before full
	task automatic wide_queue();
		logic [7:0] d;
		wr(ADDR_CONTROL, 8'h10);
		wr(ADDR_PATH_MUX, 8'h03);
		rd(ADDR_PATH_MUX, d);
		check(d, 8'h03);
		for (int i = 0; i < 16; i++) wr(ADDR_DATA, 8'(i));
		rd(ADDR_STATUS, d);
		check(d, 8'h01);
		for (int i = 16; i < 256; i++) wr(ADDR_DATA, 8'(i));
		rd(ADDR_STATUS, d);
		check(d, 8'h09);
		wr(ADDR_DATA, 8'hEE);
		rd(ADDR_STATUS, d);
		check(d, 8'h49);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		{regWrEn, regRdEn, tbSck, tbMosi, clock_phase} = 5'h00;
		tbCsN = 1'b1;
		regAddr = 16'h0000;
		regWrData = 8'h00;
		slvReply = 8'h00;
		failCount = 0;
		checksDone = 0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		reset_values();
		master_byte(2'b00, 4'h2, 1'b1, 8'hA5, 8'h04);
		master_byte(2'b01, 4'h5, 1'b0, 8'h3C, 8'h08);
		master_byte(2'b10, 4'h3, 1'b1, 8'h81, 8'h10);
		master_byte(2'b11, 4'h4, 1'b0, 8'h5A, 8'h20);
		queue_fill();
		for (int m = 0; m < 4; m++) slave_byte(2'(m), 1'b1, 8'hC3 ^ 8'(m));
		slave_byte(2'b00, 1'b0, 8'h96);
		wide_queue();
		closeOut();
	end

	initial begin
		repeat (40000) @(posedge clk);
		failCount++;
		closeOut();
	end
endmodule
